// ==== src/wts_switch.sv ====
// weekday time switch with apb control registers
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module wts_switch #(
    parameter int CYC_PER_MS = wts_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // calendar clock
    input wire wts_pkg::wts_datetime_t LOCAL_DATETIME_IN,
    // switch
    output logic SWITCH_OUT
);
    import wts_pkg::*;

    localparam int PRE_W = $clog2(CYC_PER_MS);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);

    logic en;
    logic [DAYS_W-1:0] days;
    logic [TOD_W-1:0] start_tod;
    logic [DUR_W-1:0] duration;
    logic [DUR_W-1:0] remaining;
    logic [PRE_W-1:0] pre;
    logic [TOD_W-1:0] last_tod;
    logic armed;
    wts_state_t state;
    logic sw_out;
    logic day_on;
    logic new_day;
    logic reached;
    logic pass;
    logic fire;
    logic tick;
    logic wr;
    logic rd_setup;

    // index of a register, 7 when unmapped
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        if (a == OFS_CTRL)
            return 3'h0;
        else if (a == OFS_DAYS)
            return 3'h1;
        else if (a == OFS_START)
            return 3'h2;
        else if (a == OFS_DUR)
            return 3'h3;
        else if (a == OFS_STATUS)
            return 3'h4;
        else if (a == OFS_REMAIN)
            return 3'h5;
        else
            return 3'h7;
    endfunction

    // weekday mask lookup
    function automatic logic day_hit(input logic [DAYS_W-1:0] m,
                                     input logic [2:0] w);
        logic [2:0] idx;
        idx = 3'h0;
        if (w > DAY_SAT)
            return 1'b0;
        if (w != DAY_SUN)
            idx = 3'h7 - w;
        return m[idx];
    endfunction

    // apb handshake
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && (reg_sel(PADDR) == 3'h7);
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;

    // control registers
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            en <= CTRL_RST;
            days <= DAYS_RST;
            start_tod <= START_RST;
            duration <= DUR_RST;
        end
        else if (wr)
        begin
            if (reg_sel(PADDR) == 3'h0)
                en <= PWDATA[0];
            else if (reg_sel(PADDR) == 3'h1)
                days <= PWDATA[DAYS_W-1:0];
            else if (reg_sel(PADDR) == 3'h2)
                start_tod <= PWDATA[TOD_W-1:0];
            else if (reg_sel(PADDR) == 3'h3)
                duration <= PWDATA[DUR_W-1:0];
        end
    end

    // read data, loaded in the setup phase
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            PRDATA <= 32'h00000000;
        else if (rd_setup)
        begin
            if (reg_sel(PADDR) == 3'h0)
                PRDATA <= {31'h00000000, en};
            else if (reg_sel(PADDR) == 3'h1)
                PRDATA <= {25'h0000000, days};
            else if (reg_sel(PADDR) == 3'h2)
                PRDATA <= {5'h00, start_tod};
            else if (reg_sel(PADDR) == 3'h3)
                PRDATA <= duration;
            else if (reg_sel(PADDR) == 3'h4)
                PRDATA <= {29'h00000000, day_on, armed, sw_out};
            else if (reg_sel(PADDR) == 3'h5)
                PRDATA <= remaining;
            else
                PRDATA <= 32'h00000000;
        end
    end

    // start-time detection
    assign day_on = day_hit(days, LOCAL_DATETIME_IN.weekday);
    assign reached = LOCAL_DATETIME_IN.tod_ms >= start_tod;
    assign new_day = LOCAL_DATETIME_IN.tod_ms < last_tod;
    assign pass = (armed || new_day) && reached;
    assign fire = pass && en && day_on && (days != 7'h00);

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            last_tod <= START_RST;
        else
            last_tod <= LOCAL_DATETIME_IN.tod_ms;
    end

    // one event per day: disarm on pass, rearm at midnight
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            armed <= 1'b1;
        else if (pass)
            armed <= 1'b0;
        else if (new_day)
            armed <= 1'b1;
    end

    // millisecond prescaler
    assign tick = (pre == PRE_LAST);

    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            pre <= '0;
        else if (fire || state == WTS_IDLE || tick)
            pre <= '0;
        else
            pre <= pre + PRE_W'(1);
    end

    // output state machine
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            state <= WTS_IDLE;
            remaining <= DUR_RST;
            sw_out <= 1'b0;
        end
        else
        begin
            case (state)
                WTS_IDLE:
                begin
                    if (fire)
                    begin
                        state <= WTS_ON;
                        remaining <= duration;
                        sw_out <= 1'b1;
                    end
                end
                WTS_ON:
                begin
                    if (!en)
                    begin
                        state <= WTS_IDLE;
                        remaining <= DUR_RST;
                        sw_out <= 1'b0;
                    end
                    else if (fire)
                        remaining <= duration;
                    else if (remaining == DUR_RST)
                    begin
                        state <= WTS_IDLE;
                        sw_out <= 1'b0;
                    end
                    else if (tick && remaining == DUR_W'(1))
                    begin
                        state <= WTS_IDLE;
                        remaining <= DUR_RST;
                        sw_out <= 1'b0;
                    end
                    else if (tick)
                        remaining <= remaining - DUR_W'(1);
                end
                default:
                begin
                    state <= WTS_IDLE;
                    sw_out <= 1'b0;
                end
            endcase
        end
    end

    assign SWITCH_OUT = sw_out;

    // checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);

    sequence s_one_cycle;
        SWITCH_OUT ##1 (!SWITCH_OUT || $past(fire));
    endsequence

    sequence s_counted_ms;
        tick && SWITCH_OUT && remaining > DUR_W'(1) && en && !fire;
    endsequence

    a_fire_sets_out: assert property (
        fire |=> SWITCH_OUT && remaining == $past(duration))
        else $error("output not raised at start time");

    a_count_down: assert property (
        s_counted_ms |=> remaining == $past(remaining) - DUR_W'(1))
        else $error("duration not counted down per ms");

    a_mask_zero_quiet: assert property (
        days == 7'h00 && !SWITCH_OUT |=> !SWITCH_OUT)
        else $error("event with empty weekday mask");

    a_zero_dur_pulse: assert property (
        fire && duration == DUR_RST |=> s_one_cycle)
        else $error("zero duration not a single cycle");

    a_no_cut_midnight: assert property (
        SWITCH_OUT && en && remaining > DUR_W'(1) |=> SWITCH_OUT)
        else $error("pulse cut before duration elapsed");

    a_day_gate: assert property (
        fire |-> day_hit(days, LOCAL_DATETIME_IN.weekday))
        else $error("event on unselected day");

    a_reset_defaults: assert property (
        !$past(NRST) |-> days == DAYS_RST && en)
        else $error("mask or enable wrong after reset");

    a_enable_low: assert property (
        !en |=> !SWITCH_OUT)
        else $error("output high while disabled");

    a_once_a_day: assert property (
        fire && !new_day |=> !armed ##1 (!fire || $past(new_day)))
        else $error("second event on the same day");

    sequence s_last_ms;
        tick && SWITCH_OUT && en && !fire && remaining == DUR_W'(1);
    endsequence

    a_pulse_ends: assert property (
        s_last_ms |=> !SWITCH_OUT)
        else $error("output not dropped after last ms");

    a_count_hold: assert property (
        SWITCH_OUT && en && !fire && !tick && remaining != DUR_RST
        |=> remaining == $past(remaining))
        else $error("remaining time changed between ms ticks");

    a_ms_prescale: assert property (
        SWITCH_OUT && !fire && !tick |=> pre == $past(pre) + PRE_W'(1))
        else $error("ms prescaler not counting while on");

    a_rearm_midnight: assert property (
        new_day && !pass |=> armed)
        else $error("not rearmed after midnight");

    a_start_reached: assert property (
        fire |-> LOCAL_DATETIME_IN.tod_ms >= start_tod)
        else $error("event before start time");
endmodule

// ==== src/wts_pkg.sv ====
// constants and types shared by the weekday time switch
package wts_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_DAY = 86400000;
    localparam int MAX_DUR_DAYS = 49;
    localparam longint MAX_DUR_MS =
        longint'(MAX_DUR_DAYS) * longint'(MS_PER_DAY);
    localparam int DUR_W = $clog2(MAX_DUR_MS + 1);
    localparam int TOD_W = 27;
    localparam int DAYS_W = 7;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DAYS = 8'h04;
    localparam logic [7:0] OFS_START = 8'h08;
    localparam logic [7:0] OFS_DUR = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_REMAIN = 8'h14;

    // values after reset
    localparam logic CTRL_RST = 1'b1;
    localparam logic [DAYS_W-1:0] DAYS_RST = 7'h7f;
    localparam logic [TOD_W-1:0] START_RST = 27'h0000000;
    localparam logic [DUR_W-1:0] DUR_RST = 32'h00000000;

    // weekday codes on the date-time input
    localparam logic [2:0] DAY_SUN = 3'h0;
    localparam logic [2:0] DAY_SAT = 3'h6;

    typedef struct packed {
        logic [2:0] weekday;
        logic [TOD_W-1:0] tod_ms;
    } wts_datetime_t;

    typedef enum logic [1:0] {
        WTS_IDLE = 2'b00,
        WTS_ON = 2'b01
    } wts_state_t;
endpackage

// ==== testbench/wts_cal_model.sv ====
// calendar clock model driving local date and time
`timescale 1ns/10ps
module wts_cal_model #(
    parameter int CYC_PER_MS = 4
) (
    // clock and bench control
    input wire logic clk,
    input wire logic load,
    input wire logic run,
    input wire wts_pkg::wts_datetime_t load_val,
    // date and time out
    output wts_pkg::wts_datetime_t dt
);
    import wts_pkg::*;
    int pre = 0;
    initial dt = '0;
    // time stands still unless run, one ms per CYC_PER_MS clocks
    always @(posedge clk)
    begin
        if (load)
        begin
            dt <= load_val;
            pre <= 0;
        end
        else if (run && pre < CYC_PER_MS - 1)
            pre <= pre + 1;
        else if (run)
        begin
            pre <= 0;
            dt.tod_ms <= dt.tod_ms + 1'b1;
            if (dt.tod_ms == TOD_W'(MS_PER_DAY - 1))
            begin
                dt.tod_ms <= '0;
                dt.weekday <= (dt.weekday == DAY_SAT) ? DAY_SUN :
                    dt.weekday + 1'b1;
            end
        end
    end
endmodule

// ==== testbench/weekday_time_switch_tb_top.sv ====
// self-checking bench for the weekday time switch
`timescale 1ns/10ps
module weekday_time_switch_tb_top;
    import wts_pkg::*;
    localparam int CYC = 4;
    logic clock = 0;
    logic nrst = 0;
    logic psel = 0, penable = 0, pwrite = 0, ld = 0, run = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sw, err;
    wts_datetime_t ld_val = '0;
    wts_datetime_t dt;
    logic [31:0] seed = 32'h4d73;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int cnt;

    initial
    begin
        forever #4 clock = ~clock;
    end

    wts_switch #(.CYC_PER_MS(CYC)) i_wts_switch (
        .CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LOCAL_DATETIME_IN(dt),
        .SWITCH_OUT(sw));
    wts_cal_model #(.CYC_PER_MS(CYC)) i_wts_cal_model (
        .clk(clock), .load(ld), .run(run), .load_val(ld_val), .dt(dt));

    function automatic logic [31:0] xrand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // sunday is bit 0, then bits run down from monday at bit 6
    function automatic logic day_sel(logic [6:0] m, logic [2:0] w);
        return (w == 3'h0) ? m[0] : (w == 3'h7) ? 1'b0 : m[3'h7 - w];
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_tod(input logic [2:0] w, input int t);
        @(posedge clock);
        ld <= 1'b1;
        ld_val <= {w, TOD_W'(t)};
        @(posedge clock);
        ld <= 1'b0;
    endtask

    // time of day falls back to rearm, then passes any start below 2000
    task automatic fire(input logic [2:0] w);
        set_tod(w, 1);
        set_tod(w, 2000);
    endtask

    task automatic count(input int n);
        cnt = 0;
        repeat (n)
        begin
            @(posedge clock);
            #1;
            if (sw === 1'b1)
                cnt++;
        end
    endtask

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end

    initial
    begin
        logic [6:0] m;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        count(6);
        check(cnt, 1);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, OFS_DAYS, 32'h0);
        check(rd, 32'h7f);
        apb(1'b0, 8'h20, 32'h0);
        check({rd[30:0], err}, 32'h1);
        set_tod(3'h0, 2000);
        apb(1'b1, OFS_DUR, 32'h1);
        for (int i = 0; i < 14; i++)
        begin
            m = xrand();
            if (i == 3)
                m = 7'h00;
            apb(1'b1, OFS_DAYS, {25'h0, m});
            apb(1'b1, OFS_START, xrand() % 1000 + 10);
            fire(i % 7);
            count(12);
            check(cnt, day_sel(m, i % 7) ? 4 : 0);
            set_tod(i % 7, 2001);
            count(8);
            check(cnt, 0);
        end
        apb(1'b1, OFS_DAYS, 32'h7f);
        apb(1'b1, OFS_CTRL, 32'h0);
        fire(3'h2);
        count(12);
        check(cnt, 0);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_DUR, 32'h0a);
        fire(3'h2);
        count(3);
        apb(1'b1, OFS_CTRL, 32'h0);
        count(1);
        check(sw, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_DUR, 32'h5);
        apb(1'b1, OFS_START, MS_PER_DAY - 2);
        set_tod(3'h6, 1);
        set_tod(3'h6, MS_PER_DAY - 4);
        run <= 1'b1;
        count(40);
        check(cnt, 20);
        run <= 1'b0;
        apb(1'b1, OFS_START, 32'h64);
        apb(1'b0, OFS_START, 32'h0);
        check(rd, 32'h64);
        apb(1'b1, OFS_DUR, 32'(MAX_DUR_MS));
        apb(1'b0, OFS_DUR, 32'h0);
        check(rd, 32'(MAX_DUR_MS));
        fire(3'h0);
        count(40);
        check(cnt, 40);
        apb(1'b0, OFS_REMAIN, 32'h0);
        check(rd, 32'(MAX_DUR_MS) - 32'ha);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h5);
        test_done();
    end
endmodule
